//--- pmc_params.svh
// Behaviour
// - Setting the idle select bit halts the processor after the setting write completes while clocks and peripherals run on.
// - While halted, every register and memory location keeps its contents.
// - An enabled interrupt or reset ends the processor halt; an interrupt wake clears the idle bit and resumes the processor.
// - After an interrupt wake the pending interrupt is serviced and return continues after the instruction that set idle.
// - A reset ending the processor halt runs the normal reset sequence and fetches from address 0x0000.
// - An enabled watchdog timeout during the processor halt produces an internal reset that ends the halt.
// - Setting the stop select bit stops the processor and oscillators after the setting write, shutting down digital peripherals.
// - In the clock-stopped state the system clock is halted and all interrupts and timers are idle except the clock loss detector.
// - The clock-stopped state ends only through a reset, then the normal reset sequence from address 0x0000.
// - An enabled clock loss detector issues an internal reset ending the clock-stopped state; software disables it for sleeps past 100 us.
// - The stop and idle select bits always read back as zero.
// - With the baud doubler bit set the serial baud rate is doubled, otherwise unchanged.
// - Bits 6 to 2 are five general-purpose read/write flags with no other function.
// - Once the oscillator is off only a reset restarts it.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_ADDR_W          8
`define PMC_DATA_W          8
`define PMC_REG_POWER_CTRL  8'h87
`define PMC_POWER_RESET     8'h00
`define PMC_BIT_IDLE        0
`define PMC_BIT_STOP        1
`define PMC_FLAGS_LSB       2
`define PMC_FLAGS_MSB       6
`define PMC_BIT_BAUD_DBL    7
`define PMC_RESET_VECTOR    16'h0000
`define PMC_CLD_TIMEOUT_NS  100000
`define PMC_CLK_PERIOD_NS   5

`endif

//--- pmc_pkg.sv
package pmc_pkg;
    // One-hot power states
    typedef enum logic [2:0] {
        PMC_RUN  = 3'b001,
        PMC_IDLE = 3'b010,
        PMC_STOP = 3'b100
    } pmc_state_t;
endpackage : pmc_pkg

//--- pmc_reset_catch.sv
`timescale 1ns/1ps
`include "pmc_params.svh"
// Sync a pin-level reset source: three stages, change counted once the last two agree
module pmc_reset_catch (
    input  wire logic clock_in,
    input  wire logic nrst_in,
    input  wire logic async_in,
    output logic      level_out
);
    logic [2:0] sync_q;

    // Stage 0 is read only by stage 1
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sync_q    <= 3'h0;
            level_out <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], async_in};
            if (sync_q[2] == sync_q[1]) begin
                level_out <= sync_q[2];
            end
        end
    end
endmodule : pmc_reset_catch

//--- pmc_power_mode_control.sv
`timescale 1ns/1ps
`include "pmc_params.svh"
// Power mode control: idle/stop sequencing, wake and reset requests, and the
// power control register with baud doubler and general flags.
module pmc_power_mode_control #(
    parameter int CLD_TIMEOUT_CYC = (`PMC_CLD_TIMEOUT_NS) / (`PMC_CLK_PERIOD_NS)
) (
    input  wire logic                   clock_in,
    input  wire logic                   nrst_in,
    // Register port
    input  wire logic [`PMC_ADDR_W-1:0] addr_in,
    input  wire logic [`PMC_DATA_W-1:0] wdata_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic      [`PMC_DATA_W-1:0] rdata_out,
    // Core and system side
    input  wire logic                   instr_done_in,
    input  wire logic                   irq_pending_in,
    input  wire logic                   watchdog_en_in,
    input  wire logic                   watchdog_timeout_in,
    input  wire logic                   cld_en_in,
    input  wire logic                   ext_reset_in,
    output logic                        cpu_halt_out,
    output logic                        periph_clk_en_out,
    output logic                        osc_en_out,
    output logic                        irq_accept_out,
    output logic                        timers_en_out,
    output logic                        sys_reset_req_out,
    output logic      [15:0]            reset_vector_out,
    output logic                        baud_doubler_out,
    output logic      [4:0]             general_flags_out,
    output logic      [2:0]             state_out
);
    localparam int CLD_W = $clog2(CLD_TIMEOUT_CYC + 1);

    pmc_pkg::pmc_state_t state_q;
    pmc_pkg::pmc_state_t state_d;
    logic                idle_req_q;
    logic                stop_req_q;
    logic                baud_dbl_q;
    logic [4:0]          flags_q;
    logic [CLD_W-1:0]    cld_cnt_q;
    logic                ext_reset_s;
    logic                rst_req_q;

    // Pin reset passes the three-stage sync
    pmc_reset_catch u_rst_sync (
        .clock_in  (clock_in),
        .nrst_in   (nrst_in),
        .async_in  (ext_reset_in),
        .level_out (ext_reset_s)
    );

    // Register decode
    function automatic logic hit(input logic [`PMC_ADDR_W-1:0] a);
        return a == `PMC_REG_POWER_CTRL;
    endfunction : hit

    wire wr_hit    = wr_in && hit(addr_in);
    wire rd_hit    = rd_in && hit(addr_in);
    wire set_idle  = wr_hit && wdata_in[`PMC_BIT_IDLE];
    wire set_stop  = wr_hit && wdata_in[`PMC_BIT_STOP];
    wire cld_fire  = cld_cnt_q == CLD_W'(CLD_TIMEOUT_CYC);
    wire in_idle   = state_q == pmc_pkg::PMC_IDLE;
    wire in_stop   = state_q == pmc_pkg::PMC_STOP;
    // Internal reset sources, merged with the pin reset; watchdog only live outside stop
    wire wd_reset  = watchdog_en_in && watchdog_timeout_in && !in_stop;
    wire cld_reset = cld_en_in && in_stop && cld_fire;
    wire any_reset = ext_reset_s || wd_reset || cld_reset;
    // Read value; mode bits always zero
    wire [`PMC_DATA_W-1:0] rd_val = {baud_dbl_q, flags_q, 2'b00};

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            pmc_pkg::PMC_RUN: begin
                // Request takes effect once the setting write completes
                if (stop_req_q && instr_done_in) begin
                    state_d = pmc_pkg::PMC_STOP;
                end else if (idle_req_q && instr_done_in) begin
                    state_d = pmc_pkg::PMC_IDLE;
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (irq_pending_in) begin
                    state_d = pmc_pkg::PMC_RUN;
                end
            end
            pmc_pkg::PMC_STOP: begin
                state_d = pmc_pkg::PMC_STOP;
            end
            default: begin
                state_d = pmc_pkg::PMC_RUN;
            end
        endcase
        if (any_reset) begin
            state_d = pmc_pkg::PMC_RUN;
        end
    end

    // State and pending mode requests
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_q    <= pmc_pkg::PMC_RUN;
            idle_req_q <= 1'b0;
            stop_req_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // Requests held until the halt is entered, then dropped
            idle_req_q <= any_reset ? 1'b0 : (set_idle || (idle_req_q && !(instr_done_in && !in_idle)));
            stop_req_q <= any_reset ? 1'b0 : (set_stop || (stop_req_q && !instr_done_in));
        end
    end

    // Software fields; contents held across both halts
    always_ff @(posedge clock_in) begin
        if (!nrst_in || rst_req_q) begin
            baud_dbl_q <= 1'(`PMC_POWER_RESET >> `PMC_BIT_BAUD_DBL);
            flags_q    <= 5'(`PMC_POWER_RESET >> `PMC_FLAGS_LSB);
        end else if (wr_hit) begin
            baud_dbl_q <= wdata_in[`PMC_BIT_BAUD_DBL];
            flags_q    <= wdata_in[`PMC_FLAGS_MSB:`PMC_FLAGS_LSB];
        end
    end

    // Clock loss detector counts only while the clock is stopped
    always_ff @(posedge clock_in) begin
        if (!nrst_in || !in_stop || !cld_en_in) begin
            cld_cnt_q <= '0;
        end else if (!cld_fire) begin
            cld_cnt_q <= cld_cnt_q + CLD_W'(1);
        end
    end

    // Registered outputs
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rdata_out         <= 8'h00;
            cpu_halt_out      <= 1'b0;
            periph_clk_en_out <= 1'b1;
            osc_en_out        <= 1'b1;
            irq_accept_out    <= 1'b0;
            timers_en_out     <= 1'b1;
            rst_req_q         <= 1'b0;
            sys_reset_req_out <= 1'b0;
            reset_vector_out  <= `PMC_RESET_VECTOR;
            baud_doubler_out  <= 1'b0;
            general_flags_out <= 5'h00;
            state_out         <= pmc_pkg::PMC_RUN;
        end else begin
            rdata_out         <= rd_hit ? rd_val : 8'h00;
            cpu_halt_out      <= state_d != pmc_pkg::PMC_RUN;
            periph_clk_en_out <= state_d != pmc_pkg::PMC_STOP;
            osc_en_out        <= state_d != pmc_pkg::PMC_STOP;
            timers_en_out     <= state_d != pmc_pkg::PMC_STOP;
            irq_accept_out    <= in_idle && irq_pending_in && !any_reset;
            rst_req_q         <= any_reset;
            sys_reset_req_out <= any_reset;
            reset_vector_out  <= `PMC_RESET_VECTOR;
            baud_doubler_out  <= baud_dbl_q;
            general_flags_out <= flags_q;
            state_out         <= state_d;
        end
    end
endmodule : pmc_power_mode_control

//--- pmc_core_model.sv
`timescale 1ns/1ps
// Core stand-in: reports the mode-setting instruction done a few cycles later
module pmc_core_model (
    input  wire logic       clock_in,
    input  wire logic       start_in,
    input  wire logic [3:0] lat_in,
    output logic            done_out
);
    logic [3:0] cnt_q = 4'h0;
    // Floor of two cycles, since the follower holds two opcode bytes
    always_ff @(posedge clock_in) begin
        done_out <= (cnt_q == 4'h1);
        if (start_in) cnt_q <= (lat_in < 4'h2) ? 4'h2 : lat_in;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
endmodule : pmc_core_model

//--- pmc_chk.sv
`timescale 1ns/1ps
// Ties power state outputs to their causes
module pmc_chk #(
    parameter int CLD_TIMEOUT_CYC = 20000
) (
    input wire logic       clock_in,
    input wire logic       nrst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       irq_pending_in,
    input wire logic       cld_en_in,
    input wire logic       cpu_halt_out,
    input wire logic       periph_clk_en_out,
    input wire logic       osc_en_out,
    input wire logic       timers_en_out,
    input wire logic       irq_accept_out,
    input wire logic       sys_reset_req_out,
    input wire logic       baud_doubler_out,
    input wire logic [4:0] general_flags_out,
    input wire logic [2:0] state_out
);
    int stop_cyc_q = 0;
    // Stop dwell counter, as the timeout is far past any delay range
    always_ff @(posedge clock_in) begin
        stop_cyc_q <= (nrst_in && cld_en_in && state_out == 3'h4) ? stop_cyc_q + 1 : 0;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    chk_halt_mode: assert property (cpu_halt_out == (state_out != 3'h1))
        else $error("halt flag disagrees with state");
    chk_idle_clocks: assert property (state_out == 3'h2 |-> osc_en_out && periph_clk_en_out && timers_en_out)
        else $error("clocks off in idle");
    chk_stop_clocks: assert property (state_out == 3'h4 |-> !(osc_en_out | periph_clk_en_out | timers_en_out))
        else $error("clocks on in stop");
    chk_stop_noirq: assert property (state_out == 3'h4 |-> !irq_accept_out)
        else $error("interrupt taken in stop");
    chk_irq_wake: assert property (
        state_out == 3'h2 && irq_pending_in && !sys_reset_req_out |=> state_out == 3'h1 && irq_accept_out)
        else $error("no wake on interrupt");
    chk_stop_exit: assert property (
        $past(state_out) == 3'h4 && state_out != 3'h4 |-> sys_reset_req_out || $past(sys_reset_req_out))
        else $error("stop left without reset");
    // Field register then output register: the stored value shows two edges on
    chk_flag_write: assert property (
        wr_in && addr_in == 8'h87 && !sys_reset_req_out
        |=> ##1 {2'b00, baud_doubler_out, general_flags_out} == ($past(wdata_in, 2) >> 2))
        else $error("flags or doubler not stored");
    chk_cld_bound: assert property (!(stop_cyc_q > CLD_TIMEOUT_CYC + 2))
        else $error("clock loss reset late");
    cov_wake: cover property (irq_accept_out);
    cov_stop_exit: cover property (state_out == 3'h4 ##1 state_out == 3'h1);
    cov_write: cover property (wr_in && addr_in == 8'h87);
endmodule : pmc_chk
bind pmc_power_mode_control pmc_chk #(.CLD_TIMEOUT_CYC(CLD_TIMEOUT_CYC)) u_chk (.*);

//--- tb.sv
`timescale 1ns/1ps
module tb;
    localparam int CLD = 16;
    logic clock_in, nrst_in, wr_in, rd_in, instr_done_in, irq_pending_in, watchdog_en_in, start_q, ext_reset_in;
    logic watchdog_timeout_in, cld_en_in, cpu_halt_out, periph_clk_en_out, osc_en_out, irq_accept_out;
    logic timers_en_out, sys_reset_req_out, baud_doubler_out;
    logic [7:0] addr_in, wdata_in, rdata_out;
    logic [4:0] general_flags_out;
    logic [3:0] lat;
    logic [2:0] state_out;
    logic [15:0] reset_vector_out;
    int miscompares = 0, samples_checked = 0, cyc = 0, n;
    pmc_power_mode_control #(.CLD_TIMEOUT_CYC(CLD)) DUT (.*);
    pmc_core_model u_core (.clock_in(clock_in), .start_in(start_q), .lat_in(lat), .done_out(instr_done_in));
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    // Hang guard, the run needs well under a thousand cycles
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
        @(posedge clock_in) wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in) {rd_in, addr_in} <= {1'b1, a};
        @(posedge clock_in) rd_in <= 1'b0;
        #1 check("read data", {8'h00, exp}, {8'h00, rdata_out});
    endtask : rd
    // Write the mode, then let the core finish that instruction
    task automatic go(input logic [7:0] d, input logic [3:0] l);
        wr(8'h87, d);
        {lat, start_q} <= {l, 1'b1};
        @(posedge clock_in) start_q <= 1'b0;
    endtask : go
    task automatic wait_st(input logic [2:0] s);
        n = 0;
        while (state_out !== s && n < 60) begin
            @(negedge clock_in);
            n++;
        end
    endtask : wait_st
    task automatic t_regs;
        rd(8'h87, 8'h00);
        wr(8'h87, 8'hFC);
        rd(8'h87, 8'hFC);
        check("doubler", {10'h000, baud_doubler_out, general_flags_out}, 16'h003F);
        rd(8'h86, 8'h00);
    endtask : t_regs
    task automatic t_idle;
        go(8'h55, 4'h3);
        wait_st(3'h2);
        check("idle", 16'h0017, {11'h000, state_out, cpu_halt_out, osc_en_out, timers_en_out});
        rd(8'h87, 8'h54);
        @(posedge clock_in) irq_pending_in <= 1'b1;
        @(posedge clock_in) irq_pending_in <= 1'b0;
        #1 check("wake", 16'h0003, {12'h000, state_out, irq_accept_out});
        rd(8'h87, 8'h54);
    endtask : t_idle
    task automatic t_wdog;
        @(posedge clock_in) watchdog_en_in <= 1'b1;
        go(8'h41, 4'h9);
        wait_st(3'h2);
        @(posedge clock_in) watchdog_timeout_in <= 1'b1;
        @(posedge clock_in) watchdog_timeout_in <= 1'b0;
        wait_st(3'h1);
        check("watchdog exit", 16'h0001, {15'h0000, n < 8});
        check("reset request", 16'h0001, {15'h0000, sys_reset_req_out});
        check("vector", 16'h0000, reset_vector_out);
        @(posedge clock_in) watchdog_en_in <= 1'b0;
        rd(8'h87, 8'h00);
    endtask : t_wdog
    // Interrupt held high must not end stop
    task automatic t_stop;
        @(posedge clock_in) {cld_en_in, irq_pending_in} <= 2'h3;
        go(8'h03, 4'h2); // analog side taken as already shut down
        wait_st(3'h4);
        check("stop", 16'h0020, {10'h000, state_out, osc_en_out, periph_clk_en_out, timers_en_out});
        wait_st(3'h1);
        check("loss delay", 16'h0001, {15'h0000, n >= CLD - 2 && n <= CLD + 4});
        @(posedge clock_in) {cld_en_in, irq_pending_in} <= 2'h0;
    endtask : t_stop
    task automatic t_ext;
        go(8'h01, 4'h2);
        wait_st(3'h2);
        @(posedge clock_in) ext_reset_in <= 1'b1;
        wait_st(3'h1);
        check("pin exit", 16'h0001, {15'h0000, n <= 6});
        @(posedge clock_in) ext_reset_in <= 1'b0;
    endtask : t_ext
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial begin
        {nrst_in, wr_in, rd_in, irq_pending_in, watchdog_en_in, watchdog_timeout_in, cld_en_in, ext_reset_in} = '0;
        {addr_in, wdata_in, lat, start_q} = '0;
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        t_regs();
        t_idle();
        t_wdog();
        t_stop();
        t_ext();
        finish_test();
    end
endmodule : tb
